/* design/can_err_pkg.sv */
package can_err_pkg;

    // register byte offsets on the bus, one aligned word each
    localparam logic [7:0] OFS_RXB_CTRL    = 8'h00;
    localparam logic [7:0] OFS_FILT_EXT_HI = 8'h04;
    localparam logic [7:0] OFS_FILT_EXT_LO = 8'h08;
    localparam logic [7:0] OFS_MASK_STD_HI = 8'h0C;
    localparam logic [7:0] OFS_PRIO        = 8'h10;
    localparam logic [7:0] OFS_REC         = 8'h14;
    localparam logic [7:0] OFS_TEC         = 8'h18;
    localparam logic [7:0] OFS_COMM_STAT   = 8'h1C;

    // field positions
    localparam int FULL_BIT     = 7;
    localparam int FMODE_HI_BIT = 6;
    localparam int FMODE_LO_BIT = 5;
    localparam int CS_WARN_BIT  = 0;
    localparam int CS_PASS_BIT  = 1;
    localparam int CS_BOFF_BIT  = 2;

    // values after reset
    localparam logic [7:0] PRIO_RST = 8'hFF;
    localparam logic [7:0] FILT_RST = 8'h00;

    // error counter limits and steps
    localparam logic [8:0] WARN_LIM    = 9'h060;
    localparam logic [8:0] PASSIVE_LIM = 9'h080;
    localparam logic [8:0] BUSOFF_LIM  = 9'h100;
    localparam logic [8:0] TEC_STEP    = 9'h008;
    localparam logic [8:0] TEC_MAX     = 9'h1FF;
    localparam logic [7:0] REC_RESUME  = 8'h77;

    // stuff run and bus-off recovery counts
    localparam logic [2:0] STUFF_RUN    = 3'h6;
    localparam logic [3:0] RECESS_RUN   = 4'hB;
    localparam logic [7:0] RECOV_OCC    = 8'h80;

    localparam int          CRC_W    = 15;
    localparam logic [14:0] CRC_POLY = 15'h4599;

    typedef enum logic [3:0] {
        F_IDLE     = 4'h0,
        F_SOF      = 4'h1,
        F_ARB      = 4'h2,
        F_CTRL     = 4'h3,
        F_DATA     = 4'h4,
        F_CRC      = 4'h5,
        F_CRC_DEL  = 4'h6,
        F_ACK_SLOT = 4'h7,
        F_ACK_DEL  = 4'h8,
        F_EOF      = 4'h9,
        F_IFS      = 4'hA
    } field_e;

    typedef enum logic [1:0] {
        EM_ACTIVE  = 2'h0,
        EM_PASSIVE = 2'h1,
        EM_BUSOFF  = 2'h3
    } err_mode_e;

    typedef enum logic [1:0] {
        FM_ALL_VALID = 2'h0,
        FM_STD_ONLY  = 2'h1,
        FM_EXT_ONLY  = 2'h2,
        FM_ALL_ANY   = 2'h3
    } filt_mode_e;

endpackage

/* design/can_crc15.sv */
module can_crc15 #(
    parameter int           W    = 15,
    parameter logic [W-1:0] POLY = 15'h4599
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic         clr,
    input  wire logic         shift,
    input  wire logic         din,
    output logic [W-1:0]      crc
);
    if (W < 2) $error("crc width too small");

    typedef struct packed {
        logic [W-1:0] crc;
    } crc_s;

    crc_s s_r;
    crc_s s_nxt;
    logic fb;

    // feeding the sequence back through leaves zero, so one register
    // serves both the sender's shift-out and the receiver's check
    always_comb
    begin
        s_nxt = s_r;
        fb    = s_r.crc[W-1] ^ din;
        if (clr)
        begin
            s_nxt.crc = '0;
        end
        else if (shift)
        begin
            s_nxt.crc = {s_r.crc[W-2:0], 1'b0} ^ (fb ? POLY : '0);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign crc = s_r.crc;
endmodule

/* design/can_err_ctrl.sv */
// Behaviour
// - stored message sets full flag; software clears
// - writable extended filter high/low bytes
// - mask high byte: std 10..3, ext 28..21
// - priority bits per source, reset high
// - sender shifts CRC; receiver flags mismatch
// - sender flags missing acknowledge, retransmits
// - dominant in delimiters/EOF/IFS: form error
// - sender flags sampled level differing from sent
// - no bit error on arbitration/acknowledge loss
// - six equal bits flag stuff error
// - error aborts transmission, requests retransmit
// - error-active sends dominant error frames
// - error-passive sends recessive error frames
// - bus-off neither receives nor transmits
// - both error counters readable by host
// - counters step per bus specification
// - passive when either counter reaches 128
// - bus-off when transmit counter reaches 256
// - recover after 128 runs of 11 recessive
// - error mode readable in status register
// - warning when either counter reaches 96
module can_err_ctrl
    import can_err_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack,
    input  wire logic        can_rx,
    input  wire logic        bit_tick,
    input  wire logic [3:0]  field,
    input  wire logic        tx_active,
    input  wire logic        tx_bit,
    input  wire logic        stuff_bit,
    input  wire logic        tx_frame_ok,
    input  wire logic        rx_frame_ok,
    input  wire logic        frame_done,
    input  wire logic        frame_ext,
    input  wire logic        frame_valid,
    input  wire logic        msg_stored,
    output logic             buffer_occupied_flag,
    output logic             rx_filter_mode_hi,
    output logic             rx_filter_mode_lo,
    output logic             frame_accept,
    output logic [7:0]       ext_id_filter_upper,
    output logic [7:0]       ext_id_filter_lower,
    output logic [7:0]       std_id_mask_upper,
    output logic             invalid_msg_priority,
    output logic             wakeup_priority,
    output logic             bus_error_priority,
    output logic             tx_buffer_two_priority,
    output logic             tx_buffer_one_priority,
    output logic             tx_buffer_zero_priority,
    output logic             rx_buffer_one_priority,
    output logic             rx_buffer_zero_priority,
    output logic             tx_crc_bit,
    output logic             crc_error,
    output logic             ack_error,
    output logic             form_error,
    output logic             bit_error,
    output logic             stuff_error,
    output logic             error_frame_req,
    output logic             error_frame_dominant,
    output logic             retransmit_req,
    output logic             node_enable,
    output logic [7:0]       receive_error_counter,
    output logic [8:0]       transmit_error_counter,
    output logic             error_warning_flag,
    output logic             err_passive,
    output logic             bus_off
);

    typedef struct packed {
        logic       rx_meta;
        logic       rx_sync;
        logic       ack;
        logic [31:0] dat;
        logic       full;
        logic [1:0] fmode;
        logic [7:0] filt_hi;
        logic [7:0] filt_lo;
        logic [7:0] mask_hi;
        logic [7:0] prio;
        logic [7:0] rec;
        logic [8:0] tec;
        err_mode_e  emode;
        logic       warn;
        logic [2:0] same_cnt;
        logic       last_bit;
        logic [3:0] recess_cnt;
        logic [7:0] recov_cnt;
        logic       crc_err;
        logic       ack_err;
        logic       form_err;
        logic       bit_err;
        logic       stuff_err;
        logic       err_frame;
        logic       err_dom;
        logic       retx;
        logic       accept;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    logic             req;
    logic             wr;
    logic             lvl;
    logic             tick;
    logic             zone;
    logic             crc_clr;
    logic             crc_shift;
    logic [CRC_W-1:0] crc_val;
    logic             e_bit;
    logic             e_ack;
    logic             e_form;
    logic             e_stuff;
    logic             e_crc;
    logic             e_any;
    logic             recovered;

    can_crc15 #(
        .W    (CRC_W),
        .POLY (CRC_POLY)
    ) u_crc (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .clr     (crc_clr),
        .shift   (crc_shift),
        .din     (lvl),
        .crc     (crc_val)
    );

    always_comb
    begin
        s_nxt     = s_r;
        recovered = 1'b0;
        // the pin level reaches logic only after two flops
        s_nxt.rx_meta = can_rx;
        s_nxt.rx_sync = s_r.rx_meta;
        lvl  = s_r.rx_sync;
        tick = bit_tick & (s_r.emode != EM_BUSOFF);
        zone = (field >= F_SOF) && (field <= F_CRC_DEL);

        req = wb_cyc & wb_stb & ~s_r.ack;
        wr  = req & wb_we & wb_sel[0];
        s_nxt.ack = req;
        s_nxt.dat = '0;
        if (req & ~wb_we)
        begin
            case (wb_adr)
                OFS_RXB_CTRL:    s_nxt.dat[7:0] = {s_r.full, s_r.fmode, 5'h00};
                OFS_FILT_EXT_HI: s_nxt.dat[7:0] = s_r.filt_hi;
                OFS_FILT_EXT_LO: s_nxt.dat[7:0] = s_r.filt_lo;
                OFS_MASK_STD_HI: s_nxt.dat[7:0] = s_r.mask_hi;
                OFS_PRIO:        s_nxt.dat[7:0] = s_r.prio;
                OFS_REC:         s_nxt.dat[7:0] = s_r.rec;
                OFS_TEC:         s_nxt.dat[8:0] = s_r.tec;
                OFS_COMM_STAT:
                begin
                    s_nxt.dat[CS_WARN_BIT] = s_r.warn;
                    s_nxt.dat[CS_PASS_BIT] = s_r.emode == EM_PASSIVE;
                    s_nxt.dat[CS_BOFF_BIT] = s_r.emode == EM_BUSOFF;
                end
                default:         s_nxt.dat = '0;
            endcase
        end
        if (wr)
        begin
            case (wb_adr)
                OFS_RXB_CTRL:
                begin
                    if (!wb_dat_i[FULL_BIT])
                    begin
                        s_nxt.full = 1'b0;
                    end
                    s_nxt.fmode = wb_dat_i[FMODE_HI_BIT:FMODE_LO_BIT];
                end
                OFS_FILT_EXT_HI: s_nxt.filt_hi = wb_dat_i[7:0];
                OFS_FILT_EXT_LO: s_nxt.filt_lo = wb_dat_i[7:0];
                OFS_MASK_STD_HI: s_nxt.mask_hi = wb_dat_i[7:0];
                OFS_PRIO:        s_nxt.prio    = wb_dat_i[7:0];
                default:         s_nxt.prio    = s_nxt.prio;
            endcase
        end
        // a store in the same cycle as a clear leaves the flag set
        if (msg_stored & node_enable)
        begin
            s_nxt.full = 1'b1;
        end

        s_nxt.accept = 1'b0;
        if (frame_done & node_enable)
        begin
            case (filt_mode_e'(s_r.fmode))
                FM_ALL_VALID: s_nxt.accept = frame_valid;
                FM_STD_ONLY:  s_nxt.accept = frame_valid & ~frame_ext;
                FM_EXT_ONLY:  s_nxt.accept = frame_valid & frame_ext;
                FM_ALL_ANY:   s_nxt.accept = 1'b1;
                default:      s_nxt.accept = 1'b0;
            endcase
        end

        crc_clr   = tick & (field == F_SOF);
        crc_shift = tick & ~stuff_bit & (field >= F_ARB) && (field <= F_CRC);
        e_crc     = tick & ~tx_active & (field == F_CRC_DEL) & (crc_val != '0);
        // losing arbitration or being acknowledged is not a fault
        e_bit  = tick & tx_active & (tx_bit != lvl)
               & ~(tx_bit & ~lvl & ((field == F_ARB) | (field == F_ACK_SLOT)));
        e_ack  = tick & tx_active & (field == F_ACK_SLOT) & lvl;
        e_form = tick & ~lvl & ((field == F_CRC_DEL) | (field == F_ACK_DEL)
               | (field == F_EOF) | (field == F_IFS));
        e_stuff = tick & zone & (field != F_SOF) & (lvl == s_r.last_bit)
                & (s_r.same_cnt == STUFF_RUN - 3'h1);
        e_any  = e_bit | e_ack | e_form | e_stuff | e_crc;

        if (tick)
        begin
            s_nxt.last_bit = lvl;
            if (field == F_SOF || lvl != s_r.last_bit)
            begin
                s_nxt.same_cnt = 3'h1;
            end
            else if (zone && s_r.same_cnt != STUFF_RUN)
            begin
                s_nxt.same_cnt = s_r.same_cnt + 3'h1;
            end
        end

        s_nxt.crc_err   = e_crc;
        s_nxt.ack_err   = e_ack;
        s_nxt.form_err  = e_form;
        s_nxt.bit_err   = e_bit;
        s_nxt.stuff_err = e_stuff;
        s_nxt.err_frame = e_any;
        s_nxt.err_dom   = s_r.emode == EM_ACTIVE;
        s_nxt.retx      = e_any & tx_active;

        if (e_any)
        begin
            if (tx_active)
            begin
                s_nxt.tec = (s_r.tec > TEC_MAX - TEC_STEP) ? TEC_MAX
                          : s_r.tec + TEC_STEP;
            end
            else if (s_r.rec != 8'hFF)
            begin
                s_nxt.rec = s_r.rec + 8'h01;
            end
        end
        else if (tx_frame_ok & node_enable)
        begin
            if (s_r.tec != '0)
            begin
                s_nxt.tec = s_r.tec - 9'h001;
            end
        end
        else if (rx_frame_ok & node_enable)
        begin
            if ({1'b0, s_r.rec} >= PASSIVE_LIM)
            begin
                s_nxt.rec = REC_RESUME;
            end
            else if (s_r.rec != '0)
            begin
                s_nxt.rec = s_r.rec - 8'h01;
            end
        end

        if (s_r.emode == EM_BUSOFF)
        begin
            if (bit_tick)
            begin
                if (!lvl)
                begin
                    s_nxt.recess_cnt = '0;
                end
                else if (s_r.recess_cnt == RECESS_RUN - 4'h1)
                begin
                    s_nxt.recess_cnt = '0;
                    s_nxt.recov_cnt  = s_r.recov_cnt + 8'h01;
                    recovered = s_r.recov_cnt == RECOV_OCC - 8'h01;
                end
                else
                begin
                    s_nxt.recess_cnt = s_r.recess_cnt + 4'h1;
                end
            end
            if (recovered)
            begin
                s_nxt.tec   = '0;
                s_nxt.rec   = '0;
                s_nxt.emode = EM_ACTIVE;
            end
        end
        else
        begin
            s_nxt.recess_cnt = '0;
            s_nxt.recov_cnt  = '0;
            if (s_nxt.tec >= BUSOFF_LIM)
            begin
                s_nxt.emode = EM_BUSOFF;
            end
            else if ({1'b0, s_nxt.rec} >= PASSIVE_LIM || s_nxt.tec >= PASSIVE_LIM)
            begin
                s_nxt.emode = EM_PASSIVE;
            end
            else
            begin
                s_nxt.emode = EM_ACTIVE;
            end
        end
        s_nxt.warn = ({1'b0, s_nxt.rec} >= WARN_LIM) || (s_nxt.tec >= WARN_LIM);
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_r         <= '0;
            s_r.rx_meta <= 1'b1;
            s_r.rx_sync <= 1'b1;
            s_r.last_bit <= 1'b1;
            s_r.filt_hi <= FILT_RST;
            s_r.filt_lo <= FILT_RST;
            s_r.mask_hi <= FILT_RST;
            s_r.prio    <= PRIO_RST;
            s_r.emode   <= EM_ACTIVE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack   = s_r.ack;
    assign wb_dat_o = s_r.dat;
    assign buffer_occupied_flag = s_r.full;
    assign rx_filter_mode_hi    = s_r.fmode[1];
    assign rx_filter_mode_lo    = s_r.fmode[0];
    assign frame_accept         = s_r.accept;
    assign ext_id_filter_upper  = s_r.filt_hi;
    assign ext_id_filter_lower  = s_r.filt_lo;
    // same byte masks extended bits 28..21 when extended ids compare
    assign std_id_mask_upper    = s_r.mask_hi;
    assign {invalid_msg_priority, wakeup_priority, bus_error_priority,
            tx_buffer_two_priority, tx_buffer_one_priority, tx_buffer_zero_priority,
            rx_buffer_one_priority, rx_buffer_zero_priority} = s_r.prio;
    assign tx_crc_bit           = crc_val[CRC_W-1];
    assign crc_error            = s_r.crc_err;
    assign ack_error            = s_r.ack_err;
    assign form_error           = s_r.form_err;
    assign bit_error            = s_r.bit_err;
    assign stuff_error          = s_r.stuff_err;
    assign error_frame_req      = s_r.err_frame;
    assign error_frame_dominant = s_r.err_dom;
    assign retransmit_req       = s_r.retx;
    assign node_enable          = s_r.emode != EM_BUSOFF;
    assign receive_error_counter  = s_r.rec;
    assign transmit_error_counter = s_r.tec;
    assign error_warning_flag   = s_r.warn;
    assign err_passive          = s_r.emode == EM_PASSIVE;
    assign bus_off              = s_r.emode == EM_BUSOFF;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    a_bus_ack_once: assert property (req |=> wb_ack ##1 !wb_ack)
        else $error("bus ack not a single cycle");
    a_full_set: assert property (msg_stored && node_enable |=> buffer_occupied_flag)
        else $error("full flag not set on store");
    a_ack_missing: assert property (tick && tx_active && field == F_ACK_SLOT && lvl
        |=> ack_error && retransmit_req && error_frame_req)
        else $error("missing acknowledge not flagged");
    a_arb_no_biterr: assert property (tick && field == F_ARB && tx_bit && !lvl
        |=> !bit_error)
        else $error("bit error during arbitration loss");
    a_biterr_data: assert property (tick && tx_active && field == F_DATA && tx_bit != lvl
        |=> bit_error ##1 !bit_error)
        else $error("bit error missed");
    a_err_frame_kind: assert property (error_frame_req
        |-> error_frame_dominant == ($past(s_r.emode) == EM_ACTIVE))
        else $error("error frame polarity wrong");
    a_passive_lvl: assert property (!bus_off
        |-> err_passive == (receive_error_counter >= 8'h80 || transmit_error_counter >= 9'h080))
        else $error("passive state mismatch");
    a_busoff_enter: assert property (transmit_error_counter >= 9'h100 |-> bus_off)
        else $error("bus-off not entered");
    a_busoff_quiet: assert property (bus_off |=> !error_frame_req && !frame_accept)
        else $error("activity while bus-off");
    a_recover_clear: assert property (bus_off ##1 !bus_off
        |-> transmit_error_counter == 9'h000 && receive_error_counter == 8'h00)
        else $error("recovery left counters set");
    a_warn_lvl: assert property (error_warning_flag
        == (receive_error_counter >= 8'h60 || transmit_error_counter >= 9'h060))
        else $error("warning flag mismatch");

    c_ack_error: cover property (ack_error);
    c_passive: cover property (err_passive ##1 error_frame_req);
    c_recovery: cover property (bus_off ##1 !bus_off);
    c_stuff: cover property (stuff_error);
endmodule

/* sim/can_far_node.sv */
module can_far_node
(
    input  wire logic sys_clk,
    input  wire logic slow,
    input  wire logic dom_req,
    input  wire logic node_tx,
    output logic      can_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dom_late = 1'h0;

    always_ff @(posedge sys_clk)
        dom_late <= dom_req;

    // wired-and bus: any dominant driver wins; slow mode answers a cycle late
    assign can_rx = node_tx & ~(slow ? dom_late : dom_req);
endmodule

/* sim/test_can_err_ctrl.sv */
module test_can_err_ctrl
    import can_err_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'h0, rstn = 1'h0, wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'hF, field = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic        bit_tick = 1'h0, tx_active = 1'h0, tx_bit = 1'h1, dom_req = 1'h0;
    logic        frame_done = 1'h0, frame_ext = 1'h0, frame_valid = 1'h0, msg_stored = 1'h0;
    logic        stuff_bit = 1'h0, tx_frame_ok = 1'h0, rx_frame_ok = 1'h0, slow = 1'h0;
    logic        can_rx, wb_ack, buffer_occupied_flag, rx_filter_mode_hi, rx_filter_mode_lo;
    logic        frame_accept, invalid_msg_priority, wakeup_priority, bus_error_priority;
    logic        tx_buffer_two_priority, tx_buffer_one_priority, tx_buffer_zero_priority;
    logic        rx_buffer_one_priority, rx_buffer_zero_priority, tx_crc_bit, crc_error;
    logic        ack_error, form_error, bit_error, stuff_error, error_frame_req, node_enable;
    logic        error_frame_dominant, retransmit_req, error_warning_flag, err_passive, bus_off;
    logic [7:0]  ext_id_filter_upper, ext_id_filter_lower, std_id_mask_upper;
    logic [7:0]  receive_error_counter, val_t[4];
    logic [8:0]  transmit_error_counter;
    logic [6:0]  ev;
    logic [7:0]  adr_t[4] = '{OFS_FILT_EXT_HI, OFS_FILT_EXT_LO, OFS_MASK_STD_HI, OFS_PRIO};
    logic [3:0]  ft[4] = '{F_EOF, F_IFS, F_ACK_DEL, F_CRC_DEL};
    int          seed = 30, err_count = 0, num_checks = 0, exp_tec = 0;

    always #4 sys_clk = ~sys_clk;

    can_err_ctrl dut (.*);
    can_far_node far (.sys_clk(sys_clk), .slow(slow), .dom_req(dom_req),
                      .node_tx(tx_bit | ~tx_active), .can_rx(can_rx));

    task automatic chk(input string nm, input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc   <= 1'h1;
        wb_stb   <= 1'h1;
        wb_we    <= we;
        wb_adr   <= a;
        wb_dat_i <= d;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wb_ack !== 1'h1 && n < 20);
        q = wb_dat_o;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        if (n >= 20)
        begin
            err_count++;
            report_and_stop();
        end
    endtask

    // bus level is held a few cycles so the input synchroniser has settled
    task automatic tick(input logic [3:0] f, input logic ta, tb, dm);
        @(posedge sys_clk);
        field     <= f;
        tx_active <= ta;
        tx_bit    <= tb;
        dom_req   <= dm;
        slow      <= 1'($random(seed));
        repeat (4) @(posedge sys_clk);
        bit_tick <= 1'h1;
        @(posedge sys_clk);
        bit_tick <= 1'h0;
        @(posedge sys_clk);
        ev = {crc_error, ack_error, form_error, bit_error, stuff_error, error_frame_req,
              retransmit_req};
    endtask

    function automatic logic acc(int m, logic ext, val);
        case (m)
            0: return val;
            1: return val & ~ext;
            2: return val & ext;
            default: return 1'h1;
        endcase
    endfunction

    initial
    begin
        #400000;
        err_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'h1;
        wb(1'h0, OFS_PRIO, 32'h0);
        chk("prio reset", q, 32'hFF);
        wb(1'h1, 8'h40, 32'hFF);
        wb(1'h0, 8'h40, 32'h0);
        chk("unmapped", q, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            val_t[i] = 8'($random(seed));
            wb(1'h1, adr_t[i], {24'h0, val_t[i]});
            wb(1'h0, adr_t[i], 32'h0);
            chk("readback", q, {24'h0, val_t[i]});
        end
        chk("filter", {ext_id_filter_upper, ext_id_filter_lower}, {val_t[0], val_t[1]});
        chk("mask", std_id_mask_upper, val_t[2]);
        chk("prio", {invalid_msg_priority, wakeup_priority, bus_error_priority,
            tx_buffer_two_priority, tx_buffer_one_priority, tx_buffer_zero_priority,
            rx_buffer_one_priority, rx_buffer_zero_priority}, val_t[3]);
        $display("registers done");
        for (int m = 0; m < 4; m++)
        begin
            wb(1'h1, OFS_RXB_CTRL, {24'h0, 1'h0, m[1:0], 5'h0});
            chk("mode", {rx_filter_mode_hi, rx_filter_mode_lo}, m);
            for (int c = 0; c < 4; c++)
            begin
                @(posedge sys_clk);
                frame_ext   <= c[0];
                frame_valid <= c[1];
                frame_done  <= 1'h1;
                @(posedge sys_clk);
                frame_done <= 1'h0;
                @(posedge sys_clk);
                chk("accept", frame_accept, acc(m, c[0], c[1]));
            end
        end
        @(posedge sys_clk);
        msg_stored <= 1'h1;
        @(posedge sys_clk);
        msg_stored <= 1'h0;
        wb(1'h0, OFS_RXB_CTRL, 32'h0);
        chk("full", q & 32'hE0, 32'hE0);
        wb(1'h1, OFS_RXB_CTRL, 32'h60);
        chk("full cleared", buffer_occupied_flag, 1'h0);
        $display("buffer done");
        for (int i = 0; i < 4; i++)
        begin
            tick(ft[i], 1'h0, 1'h1, 1'h1);
            chk("form", ev[4], 1'h1);
            if (i == 2)
            begin
                wb(1'h0, OFS_REC, 32'h0);
                chk("rec", q, 32'h3);
            end
        end
        tick(F_SOF, 1'h0, 1'h1, 1'h1);
        tick(F_ARB, 1'h0, 1'h1, 1'h0);
        tick(F_CRC_DEL, 1'h0, 1'h1, 1'h0);
        chk("crc", ev, 7'h42);
        tick(F_SOF, 1'h0, 1'h1, 1'h1);
        for (int i = 0; i < 5; i++)
        begin
            tick(F_DATA, 1'h0, 1'h1, 1'h1);
            chk("stuff", ev, (i == 4) ? 7'h06 : 7'h00);
        end
        @(posedge sys_clk);
        rx_frame_ok <= 1'h1;
        @(posedge sys_clk);
        rx_frame_ok <= 1'h0;
        wb(1'h0, OFS_REC, 32'h0);
        chk("rec ok", q, 32'h5);
        $display("receive errors done");
        tick(F_SOF, 1'h1, 1'h0, 1'h0);
        tick(F_ARB, 1'h1, 1'h1, 1'h1);
        chk("arb loss", ev, 7'h00);
        tick(F_ACK_SLOT, 1'h1, 1'h1, 1'h1);
        chk("acked", ev, 7'h00);
        tick(F_DATA, 1'h1, 1'h1, 1'h1);
        chk("bit", ev, 7'h0B);
        chk("active frame", error_frame_dominant, 1'h1);
        exp_tec = 8;
        for (int i = 0; i < 31; i++)
        begin
            tick(F_ACK_SLOT, 1'h1, 1'h1, 1'h0);
            chk("ack", ev, 7'h23);
            if (exp_tec != 120)
                chk("frame kind", error_frame_dominant, exp_tec < 128);
            exp_tec += 8;
            chk("tec", transmit_error_counter, exp_tec);
            chk("warn", error_warning_flag, exp_tec >= 96);
            chk("busoff", bus_off, exp_tec >= 256);
            if (exp_tec < 256)
                chk("passive", err_passive, exp_tec >= 128);
            if (exp_tec == 128)
            begin
                wb(1'h0, OFS_COMM_STAT, 32'h0);
                chk("status", q, 32'h3);
            end
        end
        wb(1'h0, OFS_TEC, 32'h0);
        chk("tec reg", q, 32'h100);
        chk("node off", node_enable, 1'h0);
        tick(F_ACK_SLOT, 1'h1, 1'h1, 1'h0);
        chk("silent", ev, 7'h00);
        $display("error states done");
        for (int i = 0; i < 1408; i++)
            tick(F_IDLE, 1'h0, 1'h1, 1'h0);
        chk("recovered", {bus_off, node_enable}, 2'h1);
        wb(1'h0, OFS_COMM_STAT, 32'h0);
        chk("status clear", q, 32'h0);
        $display("recovery done");
        report_and_stop();
    end
endmodule
